// ### rtl/acc_pkg.sv
// Package for the analog comparator control block: offsets, fields, types
package acc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_RAW_STAT = 8'h14;

  // Channel control field positions
  localparam int CTL_ENABLE = 0;
  localparam int CTL_PIN_OE = 1;
  localparam int CTL_INVERT = 2;
  localparam int CTL_REF_SEL = 3;
  localparam int CTL_EVT_LO = 4;
  localparam int CTL_EVT_HI = 5;
  localparam int CTL_IN_LO = 6;
  localparam int CTL_IN_HI = 7;
  localparam int CTL_WIDTH = 8;

  // Status field positions: output levels in low byte, events in second byte
  localparam int STAT_EVT_BASE = 8;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // Reference source choice
  typedef enum logic {
    ACC_REF_HALF_BANDGAP = 1'b0,
    ACC_REF_GENERATOR = 1'b1
  } acc_ref_e;

  // Event polarity choice
  typedef enum logic [1:0] {
    ACC_EVT_OFF = 2'h0,
    ACC_EVT_RISE = 2'h1,
    ACC_EVT_FALL = 2'h2,
    ACC_EVT_BOTH = 2'h3
  } acc_evt_e;

  // One channel's control register
  typedef struct packed {
    logic [1:0] in_sel;
    acc_evt_e evt_mode;
    acc_ref_e ref_sel;
    logic invert;
    logic pin_oe;
    logic enable;
  } acc_ctrl_s;

  // Analog-side controls for one channel
  typedef struct packed {
    logic enable;
    logic [1:0] in_sel;
    acc_ref_e ref_sel;
  } acc_ana_s;

endpackage : acc_pkg

// ### rtl/acc_sync.sv
// Three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ns
`default_nettype none
module acc_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous in, filtered out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q, s1_d;
  logic [WIDTH-1:0] s2_q, s2_d;
  logic [WIDTH-1:0] s3_q, s3_d;
  logic [WIDTH-1:0] out_q, out_d;

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1 only feeds stage 2; change accepted when stages 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_comb
      begin
        s1_d[g] = async_in[g];
        s2_d[g] = s1_q[g];
        s3_d[g] = s2_q[g];
        out_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : out_q[g];
      end
    end
  endgenerate

  // Registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule : acc_sync
`default_nettype wire

// ### rtl/acc_top.sv
// Analog comparator control: channel registers, status, pin gating, AHB-Lite
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Function
// - One or two comparator channels, each controlled on its own.
// - Each channel routes one of up to four analog input pins.
// - Reference is half band-gap or the reference voltage generator.
// - Pin enable set, with the channel enabled, drives raw unsynchronised result, inverted on request, onto the result pin.
// - Each channel has its own control register enabling and configuring it.
// - One shared status register holds every channel's output and event.
module acc_top #(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog comparator cores
  input wire logic [NUM_CH-1:0] cmp_raw,
  output acc_pkg::acc_ana_s [NUM_CH-1:0] cmp_ana,
  // Result pins and enables (enable low while driving)
  output logic [NUM_CH-1:0] cmp_result_pin,
  output logic [NUM_CH-1:0] cmp_result_pin_oe_n,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registered state
  acc_pkg::acc_ctrl_s [NUM_CH-1:0] ctrl_q, ctrl_d;
  logic [NUM_CH-1:0] evt_q, evt_d;
  logic [NUM_CH-1:0] irq_en_q, irq_en_d;
  logic [NUM_CH-1:0] lvl_prev_q, lvl_prev_d;
  logic [NUM_CH-1:0] pin_q, pin_d;
  logic [NUM_CH-1:0] oe_n_q, oe_n_d;
  logic irq_q, irq_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  // Combinational helpers
  logic [NUM_CH-1:0] cmp_sync;
  logic [NUM_CH-1:0] level;
  logic [NUM_CH-1:0] evt_hit;
  logic [NUM_CH-1:0] clr_mask;
  logic [NUM_CH-1:0] raw_stat;
  logic req;
  logic [7:0] addr;

  ////////////////////////////////////////////////////////////////////////////
  // Level for status goes through the synchroniser, not the raw path
  // Its reset value matches the resting level of a disabled core
  acc_sync #(
    .WIDTH(NUM_CH)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(cmp_raw),
    .sync_out(cmp_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel level, event detection and pin gating
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      // Synchronised level with optional inversion
      assign level[g] = ctrl_q[g].enable & (cmp_sync[g] ^ ctrl_q[g].invert);
      // Edge event by chosen polarity
      // Previous level resets low like the level, so no edge follows reset
      always_comb
      begin
        unique case (ctrl_q[g].evt_mode)
          acc_pkg::ACC_EVT_OFF: evt_hit[g] = 1'b0;
          acc_pkg::ACC_EVT_RISE: evt_hit[g] = level[g] & ~lvl_prev_q[g];
          acc_pkg::ACC_EVT_FALL: evt_hit[g] = ~level[g] & lvl_prev_q[g];
          acc_pkg::ACC_EVT_BOTH: evt_hit[g] = level[g] ^ lvl_prev_q[g];
        endcase
      end
      // Analog controls from the channel's own register
      // Controls change only through a bus write
      always_comb
      begin
        cmp_ana[g].enable = ctrl_q[g].enable;
        cmp_ana[g].in_sel = ctrl_q[g].in_sel;
        cmp_ana[g].ref_sel = ctrl_q[g].ref_sel;
      end
      // Pin path skips the synchroniser on purpose
      // Software only ever sees the filtered level
      // Raw result onto the pin; one flop keeps the output registered
      always_comb
      begin
        pin_d[g] = cmp_raw[g] ^ ctrl_q[g].invert;
        oe_n_d[g] = ~(ctrl_q[g].pin_oe & ctrl_q[g].enable);
      end
      assign raw_stat[g] = evt_q[g] & irq_en_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: zero wait states, writes land in the data phase
  // Only whole words are decoded; hsize is ignored
  // Upper address bits are not checked, so the map repeats every 256 bytes
  always_comb
  begin
    req = hsel & hready & (htrans == acc_pkg::HTRANS_NONSEQ || htrans == acc_pkg::HTRANS_SEQ);
    addr = haddr[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file next state
  // Enable and clear words use the same bit field as the status events
  always_comb
  begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    clr_mask = '0;
    wr_pend_d = req & hwrite;
    wr_addr_d = req ? addr : wr_addr_q;
    lvl_prev_d = level;
    if (wr_pend_q)
    begin
      unique case (wr_addr_q)
        acc_pkg::OFS_CTRL0: ctrl_d[0] = hwdata[acc_pkg::CTL_WIDTH-1:0];
        acc_pkg::OFS_CTRL1:
        begin
          if (NUM_CH > 1)
            ctrl_d[NUM_CH-1] = hwdata[acc_pkg::CTL_WIDTH-1:0];
        end
        acc_pkg::OFS_IRQ_EN: irq_en_d = hwdata[acc_pkg::STAT_EVT_BASE +: NUM_CH];
        acc_pkg::OFS_IRQ_CLR: clr_mask = hwdata[acc_pkg::STAT_EVT_BASE +: NUM_CH];
        default: ;
      endcase
    end
    // Sticky events: a new event wins over a clear in the same cycle
    // Interrupt taken from next values so it lines up with the status
    evt_d = (evt_q & ~clr_mask) | evt_hit;
    irq_d = |((evt_d) & irq_en_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered for the data phase
  // Unmapped and write-only offsets read as zero
  always_comb
  begin
    rdata_d = acc_pkg::WORD_ZERO;
    if (req & ~hwrite)
    begin
      unique case (addr)
        acc_pkg::OFS_CTRL0: rdata_d[acc_pkg::CTL_WIDTH-1:0] = ctrl_q[0];
        acc_pkg::OFS_CTRL1:
        begin
          if (NUM_CH > 1)
            rdata_d[acc_pkg::CTL_WIDTH-1:0] = ctrl_q[NUM_CH-1];
        end
        acc_pkg::OFS_STAT:
        begin
          rdata_d[NUM_CH-1:0] = level;
          rdata_d[acc_pkg::STAT_EVT_BASE +: NUM_CH] = evt_q;
        end
        acc_pkg::OFS_IRQ_EN: rdata_d[acc_pkg::STAT_EVT_BASE +: NUM_CH] = irq_en_q;
        acc_pkg::OFS_RAW_STAT: rdata_d[acc_pkg::STAT_EVT_BASE +: NUM_CH] = raw_stat;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Reset leaves every pin undriven and every event cleared
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= '0;
      evt_q <= '0;
      irq_en_q <= '0;
      lvl_prev_q <= '0;
      pin_q <= '0;
      oe_n_q <= '1;
      irq_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= acc_pkg::WORD_ZERO;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      evt_q <= evt_d;
      irq_en_q <= irq_en_d;
      lvl_prev_q <= lvl_prev_d;
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
      irq_q <= irq_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops; always ready, always OKAY
  // No wait state is ever needed, so a master never stalls here
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cmp_result_pin = pin_q;
  assign cmp_result_pin_oe_n = oe_n_q;
  assign irq = irq_q;

endmodule : acc_top
`default_nettype wire

// ### verif/acc_cmp_model.sv
// Behavioural comparator cores
`timescale 1ns/1ns
`default_nettype none
module acc_cmp_model (
  // Controls in, pin levels in, results out
  input wire acc_pkg::acc_ana_s [1:0] ana,
  input wire logic [7:0] pin_lvl,
  output logic [1:0] raw
);
  // An idle core rests low, never at its last result
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      raw[c] = ana[c].enable ? pin_lvl[4*c+ana[c].in_sel] : 1'b0;
    end
  end
endmodule : acc_cmp_model
`default_nettype wire

// ### verif/acc_checker.sv
// Port assertions for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module acc_checker #(
  parameter int NUM_CH = 2
) (
  // Bus, cores, pins and interrupt
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NUM_CH-1:0] cmp_raw,
  input wire acc_pkg::acc_ana_s [NUM_CH-1:0] cmp_ana,
  input wire logic [NUM_CH-1:0] cmp_result_pin,
  input wire logic [NUM_CH-1:0] cmp_result_pin_oe_n,
  input wire logic irq
);
  logic wr;
  // Write taken; registers may move up to three edges later
  assign wr = hsel && hready && htrans[1] && hwrite;
  a_bus_okay: assert property (@(posedge clk) hreadyout && !hresp)
    else $error("bus not okay");
  a_reset_quiet: assert property (@(posedge clk) rst |=> &cmp_result_pin_oe_n && !irq)
    else $error("active in reset");
  a_pin_follow: assert property (@(posedge clk) disable iff (rst) !cmp_result_pin_oe_n[0]
    && $changed(cmp_raw[0]) && !$past(wr) && !$past(wr, 2)
    |=> $changed(cmp_result_pin[0])) else $error("pin stuck");
  a_oe_enable: assert property (@(posedge clk) disable iff (rst) !cmp_result_pin_oe_n[NUM_CH-1]
    |-> cmp_ana[NUM_CH-1].enable || $past(cmp_ana[NUM_CH-1].enable)) else $error("pin while off");
  a_ana_by_bus: assert property (@(posedge clk) disable iff (rst) $changed(cmp_ana)
    |-> $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("controls moved");
  a_irq_drop: assert property (@(posedge clk) disable iff (rst) $fell(irq)
    |-> $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("irq dropped");
  a_irq_settled: assert property (@(posedge clk) disable iff (rst) $rose(irq)
    |-> $past(cmp_raw) == $past(cmp_raw, 3)) else $error("irq before sync");
endmodule : acc_checker
bind acc_top acc_checker #(.NUM_CH(NUM_CH)) u_acc_checker (.clk(clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .cmp_raw(cmp_raw), .cmp_ana(cmp_ana), .cmp_result_pin(cmp_result_pin),
  .cmp_result_pin_oe_n(cmp_result_pin_oe_n), .irq(irq));
`default_nettype wire

// ### verif/test_analog_comparator_control.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module test_analog_comparator_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] lvl = 8'h00;
  logic [31:0] hrdata;
  logic rdy;
  logic irq;
  logic [1:0] raw;
  logic [1:0] pin;
  logic [1:0] oe_n;
  acc_pkg::acc_ana_s [1:0] ana;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  // Sole slave, so its select is tied high
  acc_top u_acc_top (.clk(clk), .rst(rst), .hsel(1'b1), .haddr({24'h0, haddr}),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(), .cmp_raw(raw), .cmp_ana(ana),
    .cmp_result_pin(pin), .cmp_result_pin_oe_n(oe_n), .irq(irq));
  acc_cmp_model u_acc_cmp_model (.ana(ana), .pin_lvl(lvl), .raw(raw));
  //////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    haddr <= a;
    hwrite <= w;
    htrans <= acc_pkg::HTRANS_NONSEQ;
    do
      @(posedge clk);
    while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do
      @(posedge clk);
    while (rdy !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk("register", exp, d);
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask : wr
  //////////////////////////////////////////////////
  // Every input and reference choice reaches the core
  task automatic t_ctrl();
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h00, {24'h0, i[1:0], 2'h0, i[2], 3'h1});
      @(posedge clk);
      chk("core controls", {28'h0, 1'b1, i[1:0], i[2]}, {28'h0, ana[0]});
    end
    wr(8'h04, 32'h0000_00C2);
    rdc(8'h00, 32'h0000_00C9);
    rdc(8'h04, 32'h0000_00C2);
    rdc(8'h40, 32'h0000_0000);
    $display("t_ctrl done");
  endtask : t_ctrl
  // Pin shows the raw result, inverted on request
  task automatic t_pin();
    wr(8'h00, 32'h0000_0003);
    lvl <= 8'h01;
    repeat (3) @(posedge clk);
    chk("pin", 32'h1, {30'h0, oe_n[0], pin[0]});
    lvl <= 8'h00;
    repeat (2) @(posedge clk);
    chk("pin", 32'h0, {30'h0, oe_n[0], pin[0]});
    wr(8'h00, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk("pin", 32'h1, {30'h0, oe_n[0], pin[0]});
    wr(8'h00, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("pin", 32'h2, {30'h0, oe_n[0], pin[0]});
    $display("t_pin done");
  endtask : t_pin
  // Both channels' events in one status word, masked and cleared
  task automatic t_events();
    wr(8'h00, 32'h0000_0011);
    wr(8'h04, 32'h0000_0033);
    wr(8'h0C, 32'h0000_0300);
    lvl <= 8'h11;
    rdc(8'h08, 32'h0000_0000);
    repeat (10) @(posedge clk);
    rdc(8'h08, 32'h0000_0303);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h10, 32'h0000_0100);
    rdc(8'h08, 32'h0000_0203);
    rdc(8'h14, 32'h0000_0200);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h0C, 32'h0000_0000);
    wr(8'h00, 32'h0000_0021);
    lvl <= 8'h00;
    repeat (10) @(posedge clk);
    rdc(8'h08, 32'h0000_0300);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h0C, 32'h0000_0300);
    rdc(8'h0C, 32'h0000_0300);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h10, 32'h0000_0300);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("t_events done");
  endtask : t_events
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Hang guard, well past the run's length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_ctrl();
    t_pin();
    t_events();
    report_and_stop();
  end
endmodule : test_analog_comparator_control
`default_nettype wire
